// file: bench/crm_monitor.sv
/* checker for the clock and runtime meter unit.
   assumes it is bound into crm_unit and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module crm_monitor #(
    parameter integer TICK_CYC = 10
) (
    input wire        aclk,
    input wire        aresetn,
    input wire        sync_req,
    input wire        bcast_valid,
    input wire        sync_error,
    input wire        second_tick,
    input wire [7:0]  clock_memory,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_rvalid,
    input wire [1:0]  s_axi_rresp,
    input wire [31:0] s_axi_rdata
);
// --------------------------------
// helper counters: cycles since the last toggle or second
// --------------------------------
reg  [7:0]  prev_cm;
reg  [31:0] cm_cnt;
reg  [31:0] sec_cnt;
reg         cm_seen;
reg         sec_seen;
wire [7:0]  cm_d = clock_memory ^ prev_cm;
// the first period after reset has an unknown phase, so it is not judged
always @(posedge aclk) begin
    prev_cm <= clock_memory;
    cm_cnt <= (!aresetn || cm_d[0]) ? 32'h0 : cm_cnt + 32'h1;
    sec_cnt <= (!aresetn || second_tick) ? 32'h0 : sec_cnt + 32'h1;
    cm_seen <= aresetn && (cm_seen || cm_d[0]);
    sec_seen <= aresetn && (sec_seen || second_tick);
end
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
// --------------------------------
// assertions
// --------------------------------
a_cm_base_period: assert property (cm_seen && cm_d[0] |-> cm_cnt == TICK_CYC - 1)
    else $error("bit0 half period wrong");
a_cm_phase_link: assert property ((cm_d & ~{cm_d[5], cm_d[4], cm_d[3], cm_d[2],
    cm_d[0], cm_d[1], cm_d[0], cm_d[0]}) == 8'h00) else $error("clock bits incoherent");
a_second_period: assert property (sec_seen && second_tick |-> sec_cnt == 20 * TICK_CYC - 1)
    else $error("second tick spacing wrong");
a_sync_one_cycle: assert property (sync_req |=> !sync_req)
    else $error("sync pulse too long");
a_bcast_one_cycle: assert property (bcast_valid |=> !bcast_valid)
    else $error("broadcast too long");
a_err_after_write: assert property (sync_error |-> (s_axi_bvalid || $past(s_axi_bvalid))
    ##1 !sync_error) else $error("stray error pulse");
a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write response late");
a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h34
    |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("bad unmapped read");
c_sync: cover property (sync_req);
c_bcast: cover property (bcast_valid);
c_error: cover property (sync_error);
endmodule // crm_monitor
bind crm_unit crm_monitor #(.TICK_CYC(TICK_CYC)) u_mon (.*);
`default_nettype wire

// file: bench/crm_net_clock.sv
/* network master clock model: answers each sync request with its time.
   assumes sync_req is a one-cycle pulse in the aclk domain. */
`timescale 1ns/1ns
`default_nettype none
module crm_net_clock #(
    parameter integer LAT      = 3,
    parameter [31:0]  NET_TIME = 32'h00001388,
    parameter [31:0]  NET_DATE = 32'h40000010
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        sync_req,
    output reg         sync_in_valid,
    output reg  [31:0] sync_in_time,
    output reg  [31:0] sync_in_date
);
reg [7:0] wait_cnt;
// idle data lines flip every cycle so a stale value is never taken
always @(posedge aclk) begin
    wait_cnt <= !aresetn ? 8'h00 : sync_req ? 8'(LAT) :
                (wait_cnt != 8'h00) ? wait_cnt - 8'h01 : 8'h00;
    sync_in_valid <= aresetn && wait_cnt == 8'h01;
    sync_in_time <= (wait_cnt == 8'h01) ? NET_TIME : ~sync_in_time;
    sync_in_date <= (wait_cnt == 8'h01) ? NET_DATE : ~sync_in_date;
end
endmodule // crm_net_clock
`default_nettype wire

// file: bench/tb_top.sv
/* self-checking bench for crm_unit over axi4-lite.
   assumes TICK_CYC 10 so one second is 200 cycles. */
`timescale 1ns/1ns
`default_nettype none
`include "crm_defines.vh"
module tb_top;
localparam integer SEC = 200;
reg         aclk = 1'b0, aresetn = 1'b0, mem_reset = 1'b0, cpu_run = 1'b1;
reg         warm_restart = 1'b0, hot_restart = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
reg         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cm_q = 8'h00;
reg  [31:0] s_axi_wdata = 32'h0, d, bc_date, bc_time;
reg  [3:0]  s_axi_wstrb = 4'hF;
reg  [1:0]  r;
wire        sync_in_valid, sync_req, sync_path, bcast_valid, second_tick, sync_error;
wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [31:0] sync_in_time, sync_in_date, bcast_time, bcast_date, s_axi_rdata;
wire [7:0]  clock_memory;
wire [15:0] clock_memory_addr;
wire [1:0]  s_axi_bresp, s_axi_rresp;
integer     err_count = 0, total_checks = 0, req_n = 0, bc_n = 0, se_n = 0, t0_n = 0, t7_n = 0, n;
crm_unit #(.TICK_CYC(10)) u_dut (.*);
crm_net_clock u_net (.aclk(aclk), .aresetn(aresetn), .sync_req(sync_req),
    .sync_in_valid(sync_in_valid), .sync_in_time(sync_in_time), .sync_in_date(sync_in_date));
initial forever #25 aclk = ~aclk;
always @(posedge aclk) begin
    cm_q <= clock_memory;
    t0_n <= t0_n + (cm_q[0] !== clock_memory[0]);
    t7_n <= t7_n + (cm_q[7] !== clock_memory[7]);
    req_n <= req_n + (sync_req === 1'b1);
    se_n <= se_n + (sync_error === 1'b1);
    bc_n <= bc_n + (bcast_valid === 1'b1);
    if (bcast_valid === 1'b1) begin
        bc_time <= bcast_time;
        bc_date <= bcast_date;
    end
end
// --------------------------------
// tasks
// --------------------------------
task check(input [31:0] seen, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
endtask
task cyc(input integer c);
    repeat (c) @(posedge aclk);
endtask
task st(input [31:0] e);
    begin
        rd(`CRM_OFS_MTR_STATE);
        check(d & 32'h180, e);
    end
endtask
task wr(input [7:0] a, input [31:0] v);
    reg aw_ok, w_ok;
    begin
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            aw_ok = aw_ok || s_axi_awready === 1'b1;
            w_ok = w_ok || s_axi_wready === 1'b1;
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        @(posedge aclk);
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    end
endtask
task rd(input [7:0] a);
    begin
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (s_axi_arready !== 1'b1) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    end
endtask
task stop_test;
    begin
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    end
endtask
// --------------------------------
// tests
// --------------------------------
initial begin
    #(20000 * 50);
    err_count = err_count + 1;
    stop_test;
end
initial begin
    cyc(4);
    aresetn <= 1'b1;
    rd(`CRM_OFS_SYNC_IVL); check(d, `CRM_RST_SYNC_IVL);
    rd(`CRM_OFS_TMR_LIMIT); check(d, {16'h0000, `CRM_RST_TMR_LIMIT});
    rd(8'h3C); check(r, 32'h2);
    wr(`CRM_OFS_TIME_SET, 32'h64);
    wr(`CRM_OFS_DATE_SET, 32'h40000005);
    wr(`CRM_OFS_CTRL, 32'h100);
    rd(`CRM_OFS_TIME); check(d - 32'h64 <= 1, 1);
    rd(`CRM_OFS_DATE); check(d, 32'h40000005);
    wr(`CRM_OFS_TIME, 32'h0); check(r, 32'h2);
    n = t0_n;
    cyc(2 * SEC); check(t0_n - n, 40); check(t7_n >= 2, 1);
    cyc(3 * SEC); rd(`CRM_OFS_TIME); check(d - 32'h69 <= 1, 1);
    wr(`CRM_OFS_CTRL, 32'h200); cyc(3);
    check(bc_n, 1); check(bc_date, 32'h40000005); check(bc_time - 32'h69 <= 2, 1);
    wr(`CRM_OFS_SYNC_IVL, 32'h2);
    wr(`CRM_OFS_CTRL, 32'h3); cyc(3 * SEC);
    check(sync_path, 1); check(req_n >= 1, 1);
    rd(`CRM_OFS_TIME); check(d - 32'h1388 <= 3, 1);
    rd(`CRM_OFS_STATUS); check(d & 32'h1, 32'h1);
    n = req_n; cyc(4 * SEC); check(req_n - n, 2);
    wr(`CRM_OFS_CTRL, 32'h0);
    wr(`CRM_OFS_MTR_VAL, 32'h2A); wr(`CRM_OFS_MTR_CMD, 32'h17);
    wr(`CRM_OFS_MTR_VAL, 32'h7); wr(`CRM_OFS_MTR_CMD, 32'h10);
    rd(`CRM_OFS_MTR_READ); check(d, 32'h7);
    wr(`CRM_OFS_MTR_CMD, 32'h27);
    rd(`CRM_OFS_MTR_READ); check(d, 32'h2A);
    rd(`CRM_OFS_MTR_STATE); check(d & 32'h181, 32'h180);
    cpu_run <= 1'b0; cyc(5);
    st(32'h80);
    cpu_run <= 1'b1; mem_reset <= 1'b1; cyc(5); mem_reset <= 1'b0; cyc(5);
    rd(`CRM_OFS_MTR_READ); check(d, 32'h2A);
    hot_restart <= 1'b1; cyc(5);
    st(32'h80);
    hot_restart <= 1'b0; cyc(5);
    st(32'h180);
    warm_restart <= 1'b1; cyc(5); warm_restart <= 1'b0; cyc(5);
    st(32'h0);
    wr(`CRM_OFS_MTR_CMD, 32'h27);
    st(32'h180);
    wr(`CRM_OFS_MTR_CMD, 32'h47);
    st(32'h0);
    wr(`CRM_OFS_CTRL, 32'h4);
    wr(`CRM_OFS_TMR_USE, 32'h00800010); wr(`CRM_OFS_TMR_USE, 32'h00050011);
    cyc(3); check(se_n, 0);
    wr(`CRM_OFS_TMR_USE, 32'h00810000); cyc(3); check(se_n, 1);
    wr(`CRM_OFS_TMR_USE, 32'h00050012); cyc(3); check(se_n, 2);
    wr(`CRM_OFS_CLKMEM, 32'h1234); check(clock_memory_addr, 16'h1234);
    rd(`CRM_OFS_CLKMEM); check(d & 32'hFFFF, 32'h1234);
    stop_test;
end
endmodule // tb_top
`default_nettype wire

// file: hdl/crm_unit.v
/*
 * clock and runtime meter unit: time of day with day count and weekday,
 * sync request to a network clock, eight runtime meters, clock memory byte,
 * timer overuse check. assumes an axi4-lite master and a system that
 * reports its operating state and restart kind on plain inputs.
 */
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "crm_defines.vh"

// Notes on behaviour
// R01 - keep time in seconds, a day count as date, and weekday
// R02 - software loads new date and time and reads present date and time
// R03 - a slave requests alignment to master at the configured interval and path
// R04 - on software request the master broadcasts date and time to slaves
// R05 - meters do not count while the controller is stopped
// R06 - meter counts survive a memory reset
// R07 - after a warm restart software must restart each meter
// R08 - after a hot restart counting meters resume by themselves
// R09 - software preset value loads into the selected meter
// R10 - software starts or stops the selected meter
// R11 - meter read gives hours and a counting flag
// R12 - eight meters, index from zero
// R13 - clock memory bits toggle with equal high and low time
// R14 - clock memory byte address is a configuration value
// R15 - bit periods 2.0 1.6 1.0 0.8 0.5 0.4 0.2 0.1 seconds
// R16 - clock memory runs free of the program cycle
// R17 - too many timers raises a synchronous error to the error handler
// R18 - small family: updates only in main cycle and restart blocks
// R19 - the time of day clock is the time base for meters and alarms
// R20 - all clock memory bits derive from one 0.05 s tick
module crm_unit #(
    parameter integer TICK_CYC   = `CRM_TICK_CYC,
    parameter integer METERS     = 8
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        mem_reset,
    input  wire        cpu_run,
    input  wire        warm_restart,
    input  wire        hot_restart,
    input  wire        sync_in_valid,
    input  wire [31:0] sync_in_time,
    input  wire [31:0] sync_in_date,
    output reg         sync_req,
    output reg         sync_path,
    output reg         bcast_valid,
    output reg  [31:0] bcast_time,
    output reg  [31:0] bcast_date,
    output reg  [7:0]  clock_memory,
    output reg  [15:0] clock_memory_addr,
    output reg         second_tick,
    output reg         sync_error,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

// ----------------------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------------------
    reg  [3:0]  in_meta;
    reg  [3:0]  in_sync;
    always @(posedge aclk) begin
        in_meta <= {mem_reset, cpu_run, warm_restart, hot_restart};
        in_sync <= in_meta;
    end
    wire run_s  = in_sync[2];
    wire warm_s = in_sync[1];
    wire hot_s  = in_sync[0];

// ----------------------------------------------------------------------------
// registers
// ----------------------------------------------------------------------------
    reg  [31:0] ctrl;
    reg  [31:0] sync_ivl;
    reg  [31:0] time_set;
    reg  [31:0] date_set;
    reg  [31:0] tod_sec;
    reg  [31:0] tod_day;
    reg  [2:0]  weekday;
    reg  [15:0] tmr_limit;
    reg  [2:0]  mtr_sel;
    reg  [31:0] mtr_val;
    reg  [31:0] mtr_hours [0:METERS-1];
    reg  [11:0] mtr_secs  [0:METERS-1];
    reg  [METERS-1:0] mtr_on;
    reg  [31:0] sync_cnt;
    reg  [31:0] tick_cnt;
    reg  [4:0]  tick_in_s;
    reg         tick;
    reg  [5:0]  cm_cnt [0:7];

    function [5:0] half_period;     // in 0.05 s ticks
        input [2:0] b;
        case (b)
            3'h7:    half_period = 6'h14;
            3'h6:    half_period = 6'h10;
            3'h5:    half_period = 6'h0A;
            3'h4:    half_period = 6'h08;
            3'h3:    half_period = 6'h05;
            3'h2:    half_period = 6'h04;
            3'h1:    half_period = 6'h02;
            default: half_period = 6'h01;
        endcase
    endfunction

// ----------------------------------------------------------------------------
// axi4-lite write: address and data taken together or apart, either order
// ----------------------------------------------------------------------------
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    wire [7:0]  wa   = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wd   = w_held ? w_data : s_axi_wdata;
    wire have_aw     = aw_held || (s_axi_awvalid && s_axi_awready);
    wire have_w      = w_held || (s_axi_wvalid && s_axi_wready);
    wire wr_fire     = have_aw && have_w && !s_axi_bvalid;
    wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

    function wr_known;
        input [7:0] a;
        wr_known = (a == `CRM_OFS_CTRL) || (a == `CRM_OFS_TIME_SET) ||
                   (a == `CRM_OFS_DATE_SET) || (a == `CRM_OFS_SYNC_IVL) ||
                   (a == `CRM_OFS_CLKMEM) || (a == `CRM_OFS_MTR_CMD) ||
                   (a == `CRM_OFS_MTR_VAL) || (a == `CRM_OFS_TMR_LIMIT) ||
                   (a == `CRM_OFS_TMR_USE);
    endfunction

    // masked word written at this address in this cycle
    wire [31:0] wv = wd & wmask;
    wire wr_ctrl  = wr_fire && wa == `CRM_OFS_CTRL;
    wire wr_cmd   = wr_fire && wa == `CRM_OFS_MTR_CMD;
    wire wr_tuse  = wr_fire && wa == `CRM_OFS_TMR_USE;
    wire do_wclk  = wr_ctrl && wv[`CRM_CTRL_WR_CLK];
    wire do_bcast = wr_ctrl && wv[`CRM_CTRL_BCAST];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known(wa) ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

// ----------------------------------------------------------------------------
// configuration registers
// ----------------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl              <= 32'h0;
            sync_ivl          <= `CRM_RST_SYNC_IVL;
            time_set          <= 32'h0;
            date_set          <= 32'h0;
            clock_memory_addr <= 16'h0000;
            tmr_limit         <= `CRM_RST_TMR_LIMIT;
            mtr_sel           <= 3'h0;
            mtr_val           <= 32'h0;
        end else if (wr_fire) begin
            case (wa)
                `CRM_OFS_CTRL:      ctrl <= {29'h0, wv[2:0]};
                `CRM_OFS_TIME_SET:  time_set <= (time_set & ~wmask) | wv;
                `CRM_OFS_DATE_SET:  date_set <= (date_set & ~wmask) | wv;
                `CRM_OFS_SYNC_IVL:  sync_ivl <= (sync_ivl & ~wmask) | wv;
                `CRM_OFS_CLKMEM:    clock_memory_addr <= wv[15:0];           // R14
                `CRM_OFS_MTR_VAL:   mtr_val <= (mtr_val & ~wmask) | wv;
                `CRM_OFS_TMR_LIMIT: tmr_limit <= wv[15:0];
                `CRM_OFS_MTR_CMD:   mtr_sel <= wv[`CRM_CMD_IDX_LSB +: 3];   // R12
                default:            ;
            endcase
        end
    end

// ----------------------------------------------------------------------------
// time base: 0.05 s tick, seconds, clock memory
// ----------------------------------------------------------------------------
    // counter free of cpu state so clock memory ignores the scan cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt  <= 32'h0;
            tick      <= 1'b0;
            tick_in_s <= 5'h00;
        end else begin
            tick <= 1'b0;
            if (tick_cnt == TICK_CYC - 1) begin
                tick_cnt <= 32'h0;
                tick     <= 1'b1;                                           // R20
            end else begin
                tick_cnt <= tick_cnt + 32'h1;
            end
            if (tick)
                tick_in_s <= (tick_in_s == 5'h13) ? 5'h00 : tick_in_s + 5'h01;
        end
    end
    wire sec_now = tick && tick_in_s == 5'h13;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_cm
            always @(posedge aclk) begin
                if (!aresetn) begin
                    cm_cnt[gi]       <= 6'h00;
                    clock_memory[gi] <= 1'b0;
                end else if (tick) begin                                    // R16
                    if (cm_cnt[gi] == half_period(gi) - 6'h01) begin       // R15
                        cm_cnt[gi]       <= 6'h00;
                        clock_memory[gi] <= ~clock_memory[gi];              // R13
                    end else begin
                        cm_cnt[gi] <= cm_cnt[gi] + 6'h01;
                    end
                end
            end
        end
    endgenerate

// ----------------------------------------------------------------------------
// time of day, set, sync, broadcast
// ----------------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            tod_sec     <= 32'h0;
            tod_day     <= 32'h0;
            weekday     <= 3'h0;
            second_tick <= 1'b0;
            sync_cnt    <= 32'h0;
            sync_req    <= 1'b0;
            sync_path   <= 1'b0;
            bcast_valid <= 1'b0;
            bcast_time  <= 32'h0;
            bcast_date  <= 32'h0;
        end else begin
            second_tick <= sec_now;                                         // R19
            sync_req    <= 1'b0;
            bcast_valid <= 1'b0;
            sync_path   <= ctrl[`CRM_CTRL_PATH];
            if (do_wclk) begin                                              // R02
                tod_sec <= time_set;
                tod_day <= date_set;
                weekday <= date_set[31:29];
            end else if (ctrl[`CRM_CTRL_SLAVE] && sync_in_valid) begin      // R03
                tod_sec <= sync_in_time;
                tod_day <= sync_in_date;
                weekday <= sync_in_date[31:29];
            end else if (sec_now) begin                                     // R01
                if (tod_sec == `CRM_DAY_S - 1) begin
                    tod_sec <= 32'h0;
                    tod_day <= {(weekday == 3'h6) ? 3'h0 : weekday + 3'h1,
                                tod_day[28:0] + 29'h1};
                    weekday <= (weekday == 3'h6) ? 3'h0 : weekday + 3'h1;
                end else begin
                    tod_sec <= tod_sec + 32'h1;
                end
            end
            if (sec_now && ctrl[`CRM_CTRL_SLAVE]) begin
                if (sync_cnt + 32'h1 >= sync_ivl) begin
                    sync_cnt <= 32'h0;
                    sync_req <= 1'b1;                                       // R03
                end else begin
                    sync_cnt <= sync_cnt + 32'h1;
                end
            end
            if (do_bcast && !ctrl[`CRM_CTRL_SLAVE]) begin                   // R04
                bcast_valid <= 1'b1;
                bcast_time  <= tod_sec;
                bcast_date  <= tod_day;
            end
        end
    end

// ----------------------------------------------------------------------------
// runtime meters
// ----------------------------------------------------------------------------
    // aresetn and memory reset leave hours intact; aresetn clears only run state
    generate
        for (gi = 0; gi < METERS; gi = gi + 1) begin : g_mtr
            wire sel = wr_cmd && wv[`CRM_CMD_IDX_LSB +: 3] == gi;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    mtr_on[gi] <= 1'b0;
                end else if (sel && wv[`CRM_CMD_START]) begin               // R10
                    mtr_on[gi] <= 1'b1;
                end else if ((sel && wv[`CRM_CMD_STOP]) || warm_s) begin    // R07
                    mtr_on[gi] <= 1'b0;
                end
            end
            // hot restart keeps mtr_on, so counting resumes with run  R08
            always @(posedge aclk) begin
                if (sel && wv[`CRM_CMD_PRESET]) begin                       // R09
                    mtr_hours[gi] <= mtr_val;
                    mtr_secs[gi]  <= 12'h000;
                end else if (sec_now && mtr_on[gi] && run_s && !hot_s) begin // R05
                    if (mtr_secs[gi] == `CRM_HOUR_S - 1) begin
                        mtr_secs[gi]  <= 12'h000;
                        mtr_hours[gi] <= mtr_hours[gi] + 32'h00000001;
                    end else begin
                        mtr_secs[gi] <= mtr_secs[gi] + 12'h001;
                    end
                end
            end                                                             // R06
        end
    endgenerate

// ----------------------------------------------------------------------------
// timer overuse and block restriction
// ----------------------------------------------------------------------------
    wire [1:0] tu_blk = wv[1:0];
    wire       tu_upd = wv[`CRM_TU_UPDATE];
    wire       tu_bad = (wv[31:16] > tmr_limit) ||                          // R17
                        (ctrl[`CRM_CTRL_SMALL] && tu_upd && tu_blk == 2'h2); // R18
    always @(posedge aclk) begin
        if (!aresetn)
            sync_error <= 1'b0;
        else
            sync_error <= wr_tuse && tu_bad;                                // R17
    end

// ----------------------------------------------------------------------------
// axi4-lite read, one cycle after the address is taken
// ----------------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    wire [METERS-1:0] mtr_run = mtr_on & {METERS{run_s && !hot_s}};
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr)
                `CRM_OFS_CTRL:      s_axi_rdata <= ctrl;
                `CRM_OFS_STATUS:    s_axi_rdata <= {29'h0, sync_error, run_s, ctrl[0]};
                `CRM_OFS_TIME_SET:  s_axi_rdata <= time_set;
                `CRM_OFS_DATE_SET:  s_axi_rdata <= date_set;
                `CRM_OFS_TIME:      s_axi_rdata <= tod_sec;                 // R02
                `CRM_OFS_DATE:      s_axi_rdata <= tod_day;
                `CRM_OFS_SYNC_IVL:  s_axi_rdata <= sync_ivl;
                `CRM_OFS_CLKMEM:    s_axi_rdata <= {8'h00, clock_memory, clock_memory_addr};
                `CRM_OFS_MTR_CMD:   s_axi_rdata <= {29'h0, mtr_sel};
                `CRM_OFS_MTR_VAL:   s_axi_rdata <= mtr_val;
                `CRM_OFS_MTR_READ:  s_axi_rdata <= mtr_hours[mtr_sel];      // R11
                `CRM_OFS_MTR_STATE: s_axi_rdata <= {23'h0, mtr_run[mtr_sel], mtr_on}; // R11
                `CRM_OFS_TMR_LIMIT: s_axi_rdata <= {16'h0000, tmr_limit};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // crm_unit
`default_nettype wire

// file: shared/crm_defines.vh
/*
 * register map, field positions, reset values and timing counts of the
 * clock and runtime meter unit. assumes a 20 MHz aclk.
 */
`ifndef CRM_DEFINES_VH
`define CRM_DEFINES_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define CRM_OFS_CTRL      8'h00
`define CRM_OFS_STATUS    8'h04
`define CRM_OFS_TIME_SET  8'h08
`define CRM_OFS_DATE_SET  8'h0C
`define CRM_OFS_TIME      8'h10
`define CRM_OFS_DATE      8'h14
`define CRM_OFS_SYNC_IVL  8'h18
`define CRM_OFS_CLKMEM    8'h1C
`define CRM_OFS_MTR_CMD   8'h20
`define CRM_OFS_MTR_VAL   8'h24
`define CRM_OFS_MTR_READ  8'h28
`define CRM_OFS_MTR_STATE 8'h2C
`define CRM_OFS_TMR_LIMIT 8'h30
`define CRM_OFS_TMR_USE   8'h34

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define CRM_CTRL_SLAVE    0
`define CRM_CTRL_PATH     1
`define CRM_CTRL_SMALL    2
`define CRM_CTRL_WR_CLK   8
`define CRM_CTRL_BCAST    9

// meter command fields
`define CRM_CMD_IDX_LSB   0
`define CRM_CMD_PRESET    4
`define CRM_CMD_START     5
`define CRM_CMD_STOP      6

// timer-use fields: block kind 0 main, 1 restart, 2 other; bit 4 update
`define CRM_TU_UPDATE     4

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define CRM_RST_SYNC_IVL  32'h0000003C
`define CRM_RST_TMR_LIMIT 16'h0080
`define CRM_CLK_HZ        20000000
`define CRM_TICK_MS       50
`define CRM_TICK_CYC      ((`CRM_CLK_HZ / 1000) * `CRM_TICK_MS)
`define CRM_HOUR_S        3600
`define CRM_DAY_S         86400

`endif
